// file: design/wdt_core.sv
// Purpose: Windowed watchdog with AXI4-Lite registers.
// Assumes: osc_tick_in is a same-clock pulse per osc_derived_clock cycle.
// Notes: Single clock; reset requests are one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
module wdt_core
  import wdt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic osc_tick_in,
  input wire logic special_mode_in,
  input wire logic wait_mode_in,
  input wire logic stop_in_wait_in,
  input wire logic clkmon_fail_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  output logic wdt_reset_out,
  output logic clkmon_reset_out,
  output logic irq_out
);
  logic [7:0] ctl_q;
  logic rate_wr_q, win_wr_q, special_q, strap_done_q;
  logic [PRESCALE_BITS-1:0] pre_q;
  logic [10:0] cnt_q;
  logic armed_q;
  logic [7:0] aw_q, ar_q;
  logic [31:0] wd_q;
  logic [3:0] wstrb_q;
  logic aw_v_q, w_v_q;
  logic [4:0] st_q, msk_q;
  logic wdt_rst_q, cm_rst_q;
  logic [31:0] rdata_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;

  // Counter length in prescaler ticks per rate code
  function automatic logic [10:0] wdt_limit(input logic [2:0] r);
    unique case (r)
      3'h1: wdt_limit = 11'h001;
      3'h2: wdt_limit = 11'h004;
      3'h3: wdt_limit = 11'h010;
      3'h4: wdt_limit = 11'h040;
      3'h5: wdt_limit = 11'h100;
      3'h6: wdt_limit = 11'h200;
      3'h7: wdt_limit = 11'h400;
      default: wdt_limit = 11'h000;
    endcase
  endfunction

  logic [2:0] rate;
  logic enabled, pre_tick, run, wr_go, rd_go, svc_wr, ctl_wr;
  logic [7:0] wbyte, rd_addr;
  logic [10:0] lim;
  logic timeout, in_window, bad_key, early, force_on, wdt_fail, cm_fail;
  assign rate = ctl_q[CTL_RATE_LSB +: 3];
  assign enabled = (rate != 3'h0);
  assign lim = wdt_limit(rate);
  assign run = !(stop_in_wait_in && wait_mode_in);
  assign pre_tick = osc_tick_in && (pre_q == '1);
  assign wr_go = aw_v_q && w_v_q && !bvalid_q;
  assign rd_go = s_axi_arvalid_in && !rvalid_q;
  assign wbyte = wd_q[7:0];
  assign svc_wr = wr_go && aw_q == WDT_ADDR_SERVICE;
  assign rd_addr = {s_axi_araddr_in[7:2], 2'b00};
  assign ctl_wr = wr_go && aw_q == WDT_ADDR_CONTROL;
  // Time-out at full count; counter counts prescaler ticks of 2^13 osc cycles
  assign timeout = enabled && run && pre_tick && (cnt_q == lim - 11'h001);
  // Window is last quarter of count; at the fastest rate it is never open
  assign in_window = (cnt_q >= lim - (lim >> 2)) && (lim > 11'h001);
  assign bad_key = svc_wr && enabled && wbyte != KEY_ARM && wbyte != KEY_RESTART;
  assign early = svc_wr && enabled && ctl_q[CTL_WINDOWED] && !in_window && !bad_key;
  assign force_on = ctl_q[CTL_FORCE] && !ctl_q[CTL_RESET_DISABLE];
  assign wdt_fail = !ctl_q[CTL_RESET_DISABLE] && (timeout || bad_key || early || (force_on && enabled));
  // Monitor failure outranks watchdog when both are forced together
  assign cm_fail = !ctl_q[CTL_RESET_DISABLE] && ctl_q[CTL_CLKMON_EN]
                   && (clkmon_fail_in || force_on);

  // Mode strap caught after reset release
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      special_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      special_q <= special_mode_in;
      strap_done_q <= 1'b1;
    end
  end

  // Shared prescaler is never cleared by service
  always_ff @(posedge clk_in) begin
    if (!rstn_in) pre_q <= '0;
    else if (osc_tick_in && run) pre_q <= pre_q + 1'b1;
  end

  // Watchdog counter and key sequence
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cnt_q <= '0;
      armed_q <= 1'b0;
    end else if (wdt_fail || cm_fail || !enabled) begin
      cnt_q <= '0;
      armed_q <= 1'b0;
    end else begin
      if (run && pre_tick) cnt_q <= cnt_q + 11'h001;
      if (svc_wr && wbyte == KEY_ARM) armed_q <= 1'b1;
      else if (svc_wr && wbyte == KEY_RESTART) begin
        if (armed_q) cnt_q <= '0;
        armed_q <= 1'b0;
      end
    end
  end

  // One-cycle reset requests
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      wdt_rst_q <= 1'b0;
      cm_rst_q <= 1'b0;
    end else begin
      wdt_rst_q <= wdt_fail && !cm_fail && !wdt_rst_q && !cm_rst_q;
      cm_rst_q <= cm_fail && !wdt_rst_q && !cm_rst_q;
    end
  end
  assign wdt_reset_out = wdt_rst_q;
  assign clkmon_reset_out = cm_rst_q;

  // Control register with write-once and special-only fields
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ctl_q <= CTL_RESET_NORMAL;
      rate_wr_q <= 1'b0;
      win_wr_q <= 1'b0;
    end else if (!strap_done_q) begin
      ctl_q <= special_mode_in ? CTL_RESET_SPECIAL : CTL_RESET_NORMAL;
    end else if (ctl_wr && wstrb_q[0]) begin
      ctl_q[CTL_CLKMON_EN] <= wbyte[CTL_CLKMON_EN];
      if (special_q || !rate_wr_q) begin
        ctl_q[CTL_RATE_LSB +: 3] <= wbyte[CTL_RATE_LSB +: 3];
        rate_wr_q <= 1'b1;
      end
      if (special_q || !win_wr_q) begin
        ctl_q[CTL_WINDOWED] <= wbyte[CTL_WINDOWED];
        win_wr_q <= 1'b1;
      end
      if (special_q) begin
        ctl_q[CTL_FORCE] <= wbyte[CTL_FORCE];
        ctl_q[CTL_RESET_DISABLE] <= wbyte[CTL_RESET_DISABLE];
      end
    end
  end

  // Event status and mask
  logic [4:0] ev;
  assign ev = {svc_wr && wbyte == KEY_RESTART && armed_q, force_on && (enabled || ctl_q[CTL_CLKMON_EN]),
               early, bad_key, timeout};
  always_ff @(posedge clk_in) begin
    if (!rstn_in) st_q <= '0;
    else if (rd_go && rd_addr == WDT_ADDR_STATUS) st_q <= ev;
    else st_q <= st_q | ev;
  end
  always_ff @(posedge clk_in) begin
    if (!rstn_in) msk_q <= '0;
    else if (wr_go && aw_q == WDT_ADDR_MASK && wstrb_q[0]) msk_q <= wbyte[4:0];
  end
  assign irq_out = |(st_q & msk_q);

  // AXI4-Lite write capture
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      aw_v_q <= 1'b0;
      w_v_q <= 1'b0;
      aw_q <= '0;
      wd_q <= '0;
      wstrb_q <= '0;
    end else if (wr_go) begin
      aw_v_q <= 1'b0;
      w_v_q <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_v_q <= 1'b1;
        aw_q <= {s_axi_awaddr_in[7:2], 2'b00};
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_v_q <= 1'b1;
        wd_q <= s_axi_wdata_in;
        wstrb_q <= s_axi_wstrb_in;
      end
    end
  end
  assign s_axi_awready_out = !aw_v_q && !bvalid_q;
  assign s_axi_wready_out = !w_v_q && !bvalid_q;

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      bvalid_q <= 1'b0;
      bresp_q <= AXI_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= (aw_q == WDT_ADDR_SERVICE || aw_q == WDT_ADDR_CONTROL || aw_q == WDT_ADDR_MASK
                  || aw_q == WDT_ADDR_STATUS || aw_q == WDT_ADDR_MODE) ? AXI_OKAY : AXI_SLVERR;
    end else if (s_axi_bready_in) bvalid_q <= 1'b0;
  end
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;

  // AXI4-Lite read
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= AXI_OKAY;
      ar_q <= '0;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      ar_q <= s_axi_araddr_in;
      rresp_q <= AXI_OKAY;
      unique case (rd_addr)
        WDT_ADDR_SERVICE: rdata_q <= 32'h0000_0000;
        WDT_ADDR_CONTROL: rdata_q <= {24'h0, ctl_q};
        WDT_ADDR_STATUS: rdata_q <= {27'h0, st_q};
        WDT_ADDR_MASK: rdata_q <= {27'h0, msk_q};
        WDT_ADDR_MODE: rdata_q <= {29'h0, armed_q, wait_mode_in && stop_in_wait_in, special_q};
        default: begin
          rdata_q <= 32'h0000_0000;
          rresp_q <= AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rready_in) rvalid_q <= 1'b0;
  end
  assign s_axi_arready_out = !rvalid_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

  // Checks
  property bad_key_resets;
    @(posedge clk_in) disable iff (!rstn_in)
      (bad_key && !ctl_q[CTL_RESET_DISABLE] && !cm_fail && !wdt_rst_q && !cm_rst_q) |=> wdt_reset_out;
  endproperty
  bad_key_reset_a: assert property (bad_key_resets) else $error("bad key no reset");
  pulse_single_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wdt_reset_out |=> !wdt_reset_out) else $error("reset not one cycle");
  disable_quiet_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    $past(ctl_q[CTL_RESET_DISABLE]) && ctl_q[CTL_RESET_DISABLE] |-> !wdt_reset_out && !clkmon_reset_out)
    else $error("reset while disabled");
  both_one_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !(wdt_reset_out && clkmon_reset_out)) else $error("two vectors");
  service_zero_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    rd_go && s_axi_araddr_in == WDT_ADDR_SERVICE |=> rdata_q == 32'h0) else $error("service reads nonzero");
  early_reset_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    early && !ctl_q[CTL_RESET_DISABLE] && !cm_fail && !wdt_rst_q && !cm_rst_q |=> wdt_reset_out)
    else $error("early write kept");
  clear_after_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wdt_fail |=> cnt_q == 11'h0 && !armed_q) else $error("state not cleared");
  sequence restart_s;
    svc_wr && wbyte == KEY_RESTART && armed_q && !wdt_fail && !cm_fail && enabled;
  endsequence
  restart_clear_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    restart_s |=> cnt_q == 11'h0) else $error("restart missed");
  force_lock_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    strap_done_q && !special_q && $past(strap_done_q) |-> $stable(ctl_q[CTL_FORCE]))
    else $error("force written in normal mode");
  wait_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !run && !wdt_fail && !cm_fail && !svc_wr && enabled |=> $stable(cnt_q)) else $error("ran in wait");
  // Window service and time-out steps
  sequence window_arm_s;
    svc_wr && enabled && ctl_q[CTL_WINDOWED] && in_window && wbyte == KEY_ARM;
  endsequence
  sequence quiet_s;
    !timeout && !cm_fail && !force_on;
  endsequence
  sequence timeout_s;
    timeout && !ctl_q[CTL_RESET_DISABLE] && !cm_fail;
  endsequence
  sequence idle_s;
    !wdt_rst_q && !cm_rst_q;
  endsequence
  window_ok_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    window_arm_s ##0 quiet_s |=> !wdt_reset_out) else $error("arm in window reset");
  timeout_pulse_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    timeout_s ##0 idle_s |=> wdt_reset_out) else $error("time-out no reset");
  off_quiet_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !enabled |=> !wdt_reset_out) else $error("reset while off");
  cm_off_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !ctl_q[CTL_CLKMON_EN] |=> !clkmon_reset_out) else $error("monitor reset while off");
  rate_lock_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !special_q && rate_wr_q && $past(rate_wr_q) |-> $stable(ctl_q[CTL_RATE_LSB +: 3]))
    else $error("rate written twice");
  win_lock_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    !special_q && win_wr_q && $past(win_wr_q) |-> $stable(ctl_q[CTL_WINDOWED]))
    else $error("window bit written twice");
  reset_disable_lock_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    strap_done_q && !special_q && $past(strap_done_q) |-> $stable(ctl_q[CTL_RESET_DISABLE]))
    else $error("disable written in normal mode");
  prescale_free_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    wdt_fail && osc_tick_in && run |=> pre_q == $past(pre_q) + 1'b1)
    else $error("prescaler cleared");
  restart_arm_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    svc_wr && wbyte == KEY_RESTART && !armed_q && !pre_tick && !wdt_fail && !cm_fail && enabled
    |=> cnt_q == $past(cnt_q)) else $error("restart without arm");
  bresp_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped");
  rdata_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped");
  sticky_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    st_q[ST_BADKEY] && !(rd_go && rd_addr == WDT_ADDR_STATUS) |=> st_q[ST_BADKEY])
    else $error("status bit lost");
endmodule
`default_nettype wire

// file: shared/wdt_pkg.sv
// Purpose: Constants for the windowed watchdog block.
// Assumes: 32-bit AXI4-Lite data, byte addresses.
// Notes: Rate codes map to divide exponents.
package wdt_pkg;
  localparam logic [7:0] WDT_SERVICE_OFFS = 8'h17;
  localparam logic [7:0] WDT_CONTROL_OFFS = 8'h16;
  localparam int WDT_SERVICE_IDX = 'h17;
  localparam int WDT_CONTROL_IDX = 'h16;
  localparam logic [7:0] WDT_ADDR_SERVICE = 8'(WDT_SERVICE_IDX * 4);
  localparam logic [7:0] WDT_ADDR_CONTROL = 8'(WDT_CONTROL_IDX * 4);
  localparam logic [7:0] WDT_ADDR_STATUS = 8'h60;
  localparam logic [7:0] WDT_ADDR_MASK = 8'h64;
  localparam logic [7:0] WDT_ADDR_MODE = 8'h68;
  localparam int CTL_RATE_LSB = 0;
  localparam int CTL_RESET_DISABLE = 3;
  localparam int CTL_WINDOWED = 4;
  localparam int CTL_FORCE = 5;
  localparam int CTL_CLKMON_EN = 7;
  localparam logic [7:0] CTL_RESET_NORMAL = 8'h07;
  localparam logic [7:0] CTL_RESET_SPECIAL = 8'h0f;
  localparam logic [7:0] KEY_ARM = 8'h55;
  localparam logic [7:0] KEY_RESTART = 8'haa;
  localparam int PRESCALE_BITS = 13;
  localparam int ST_TIMEOUT = 0;
  localparam int ST_BADKEY = 1;
  localparam int ST_EARLY = 2;
  localparam int ST_FORCED = 3;
  localparam int ST_SERVICED = 4;
  localparam logic [1:0] AXI_OKAY = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage

// file: verification/wdt_core_tb.sv
// Purpose: Self-checking bench for the windowed watchdog core.
// Assumes: osc_tick_in held high, so one prescaler tick is 8192 cycles.
// Notes: Register table rows first, then normal-mode timing, then special mode.
`timescale 1ns/1ns
`default_nettype none
module wdt_core_tb;
  import wdt_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e; logic [1:0] r;} wdt_row_t;
  typedef struct packed {logic [7:0] c; logic f; logic ew; logic ec;} wdt_frow_t;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic spec = 1'b0, wt = 1'b0, sw = 1'b0, cm_fail = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, wrst, crst, irq, prev_w;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  int fail_count = 0, samples_checked = 0, cyc = 0, nw = 0, nc = 0, t, a, b;
  bit dbl = 1'b0;
  wdt_row_t rows [10] = '{
    '{1'b0, WDT_ADDR_CONTROL, 32'h0, {24'h0, CTL_RESET_NORMAL}, AXI_OKAY},
    '{1'b0, WDT_ADDR_SERVICE, 32'h0, 32'h0, AXI_OKAY},
    '{1'b0, 8'h70, 32'h0, 32'h0, AXI_SLVERR},
    '{1'b1, 8'h70, 32'h0, 32'h0, AXI_SLVERR},
    '{1'b1, WDT_ADDR_CONTROL, 32'h29, 32'h0, AXI_OKAY},
    '{1'b0, WDT_ADDR_CONTROL, 32'h0, 32'h01, AXI_OKAY},
    '{1'b1, WDT_ADDR_CONTROL, 32'h13, 32'h0, AXI_OKAY},
    '{1'b0, WDT_ADDR_CONTROL, 32'h0, 32'h01, AXI_OKAY},
    '{1'b0, WDT_ADDR_MODE, 32'h0, 32'h0, AXI_OKAY},
    '{1'b1, WDT_ADDR_SERVICE, 32'haa, 32'h0, AXI_OKAY}};
  wdt_frow_t frows [8] = '{
    '{8'h2f, 1'b0, 1'b0, 1'b0},
    '{8'h27, 1'b0, 1'b1, 1'b0},
    '{8'ha0, 1'b0, 1'b0, 1'b1},
    '{8'ha7, 1'b0, 1'b0, 1'b1},
    '{8'h20, 1'b0, 1'b0, 1'b0},
    '{8'h07, 1'b1, 1'b0, 1'b0},
    '{8'h87, 1'b1, 1'b0, 1'b1},
    '{8'h8f, 1'b1, 1'b0, 1'b0}};

  wdt_core wdt_core_i (.clk_in(clk_in), .rstn_in(rstn_in), .osc_tick_in(1'b1), .special_mode_in(spec),
    .wait_mode_in(wt), .stop_in_wait_in(sw), .clkmon_fail_in(cm_fail), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .wdt_reset_out(wrst), .clkmon_reset_out(crst),
    .irq_out(irq));

  initial begin
    forever #20 clk_in = ~clk_in;
  end

  // Pulse counters, back-to-back watchdog pulse flag, hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    nw <= nw + int'(wrst === 1'b1);
    nc <= nc + int'(crst === 1'b1);
    prev_w <= wrst;
    if (wrst === 1'b1 && prev_w === 1'b1) begin
      dbl <= 1'b1;
    end
    if (cyc == 50000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic do_reset(input logic s);
    rstn_in <= 1'b0;
    spec <= s;
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (2) @(posedge clk_in);
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
    bit ha, hw;
    ha = 1'b0;
    hw = 1'b0;
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ha && hw)) begin
      @(posedge clk_in);
      if (awvalid && awready) begin
        ha = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        hw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge clk_in); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    araddr <= ad;
    arvalid <= 1'b1;
    do @(posedge clk_in); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk_in); while (rvalid !== 1'b1);
    dt = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic await_w(output int n);
    int c0;
    c0 = nw;
    n = 0;
    while (nw == c0 && n < 9000) begin
      @(posedge clk_in);
      n++;
    end
  endtask

  initial begin
    do_reset(1'b0);
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d, r);
      else rd(rows[i].a, d, r);
      if (!rows[i].w) chk(d, rows[i].e);
      chk({30'h0, r}, {30'h0, rows[i].r});
    end
    await_w(t);
    await_w(t);
    chk(t, 32'd8192);
    a = nw;
    wr(WDT_ADDR_SERVICE, {24'h0, KEY_ARM}, r);
    rd(WDT_ADDR_MODE, d, r);
    chk(d, 32'h4);
    wr(WDT_ADDR_SERVICE, {24'h0, KEY_ARM}, r);
    wr(WDT_ADDR_SERVICE, {24'h0, KEY_RESTART}, r);
    rd(WDT_ADDR_MODE, d, r);
    chk(d, 32'h0);
    rd(WDT_ADDR_STATUS, d, r);
    chk(d & 32'h1f, 32'h11);
    chk(nw - a, 32'h0);
    wr(WDT_ADDR_MASK, 32'h02, r);
    wr(WDT_ADDR_SERVICE, 32'h12, r);
    repeat (3) @(posedge clk_in);
    chk(nw - a, 32'h1);
    chk({31'h0, irq}, 32'h1);
    rd(WDT_ADDR_STATUS, d, r);
    chk(d & 32'h2, 32'h2);
    @(posedge clk_in);
    chk({31'h0, irq}, 32'h0);
    await_w(t);
    chk({31'h0, t < 8192}, 32'h1);
    do_reset(1'b1);
    rd(WDT_ADDR_CONTROL, d, r);
    chk(d, {24'h0, CTL_RESET_SPECIAL});
    foreach (frows[i]) begin
      wr(WDT_ADDR_CONTROL, {24'h0, frows[i].c}, r);
      repeat (4) @(posedge clk_in);
      a = nw;
      b = nc;
      cm_fail <= frows[i].f;
      repeat (16) @(posedge clk_in);
      chk({31'h0, nw != a}, {31'h0, frows[i].ew});
      chk({31'h0, nc != b}, {31'h0, frows[i].ec});
      cm_fail <= 1'b0;
    end
    wr(WDT_ADDR_CONTROL, 32'h01, r);
    wt <= 1'b1;
    sw <= 1'b1;
    rd(WDT_ADDR_MODE, d, r);
    chk(d & 32'h3, 32'h3);
    a = nw;
    repeat (9000) @(posedge clk_in);
    chk(nw - a, 32'h0);
    wt <= 1'b0;
    sw <= 1'b0;
    wr(WDT_ADDR_CONTROL, 32'h17, r);
    rd(WDT_ADDR_STATUS, d, r);
    a = nw;
    wr(WDT_ADDR_SERVICE, {24'h0, KEY_ARM}, r);
    repeat (3) @(posedge clk_in);
    chk(nw - a, 32'h1);
    rd(WDT_ADDR_STATUS, d, r);
    chk(d & 32'h4, 32'h4);
    chk({31'h0, dbl}, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
